// ===== common/isc_pkg.sv
// isc_pkg: constants for the two-wire slave front end
// assumes: a single 125 MHz core clock; the bus lines arrive as raw pins
package isc_pkg;
  // core clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // port mode select encodings (two bits)
  localparam logic [1:0] MODE_7BIT      = 2'h0;
  localparam logic [1:0] MODE_10BIT     = 2'h1;
  localparam logic [1:0] MODE_7BIT_SP   = 2'h2;
  localparam logic [1:0] MODE_10BIT_SP  = 2'h3;
  // high address byte pattern in 10-bit mode: 11110 a9 a8, then the direction bit
  localparam logic [4:0] TEN_BIT_HDR    = 5'h1e;
  localparam int unsigned A98_HI_POS    = 2;
  localparam int unsigned A98_LO_POS    = 1;
  // bit counts within a byte
  localparam logic [3:0] BIT_ACK_SLOT   = 4'h8;
  localparam logic [3:0] BIT_LAST       = 4'h9;
  // reset values
  localparam logic [7:0] ADDR_RST       = 8'h00;
  localparam logic [7:0] MASK_RST       = 8'hff;
  // slave transfer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WAIT_UA,
    ST_RX,
    ST_TX
  } isc_state_t;
endpackage : isc_pkg

// ===== core/isc_cond.sv
// isc_cond: start, stop and scl edge detection on synchronised lines
// assumes: sda and scl already synchronised to clk
`timescale 1ns/1ps
module isc_cond
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sda,
  input  wire logic scl,
  output logic      start_det,
  output logic      stop_det,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      bus_idle
);
  logic sda_d_r;
  logic scl_d_r;
  logic low_seen_r;
  logic busy_r;

  // previous sample of each line
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b1;
    end
    else
    begin
      sda_d_r <= sda;
      scl_d_r <= scl;
    end
  end

  // conditions only while scl stays high
  assign start_det = sda_d_r & ~sda & scl & scl_d_r;
  assign stop_det  = ~sda_d_r & sda & scl & scl_d_r & low_seen_r;
  assign scl_rise  = ~scl_d_r & scl;
  assign scl_fall  = scl_d_r & ~scl;

  // one scl low period needed since start before a stop counts
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_seen_r <= 1'b0;
    else if (start_det)
      low_seen_r <= 1'b0;
    else if (~scl)
      low_seen_r <= 1'b1;
  end

  // bus busy between start and stop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_r <= 1'b0;
    else if (start_det)
      busy_r <= 1'b1;
    else if (stop_det)
      busy_r <= 1'b0;
  end

  assign bus_idle = ~busy_r & sda & scl;
endmodule : isc_cond

// ===== core/isc_slave.sv
// isc_slave: slave front end of a two-wire serial port
// assumes: external master drives scl; pins are open drain, resolved
// outside from the enables; software bits are plain ports
`timescale 1ns/1ps
module isc_slave
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic [1:0] port_mode_select,
  input  wire logic [7:0] slave_address_reg,
  input  wire logic       addr_write,
  input  wire logic [7:0] addr_mask,
  input  wire logic       start_irq_enable,
  input  wire logic       stop_irq_enable,
  input  wire logic       address_hold_enable,
  input  wire logic       data_hold_enable,
  input  wire logic       ack_value_select,
  input  wire logic       clock_release,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_load,
  input  wire logic       buf_read,
  input  wire logic       irq_clear,
  input  wire logic       ovf_clear,
  input  wire logic       coll_clear,
  output logic [7:0]      rx_tx_buffer,
  output logic            buffer_full_flag,
  output logic            receive_overflow_flag,
  output logic            ack_received_status,
  output logic            ack_time_status,
  output logic            port_interrupt_flag,
  output logic            address_update_needed,
  output logic            prior_match,
  output logic            read_dir,
  output logic            start_seen,
  output logic            stop_seen,
  output logic            bus_collision,
  output logic            bus_idle
);
  logic sda_s;
  logic scl_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  isc_pkg::isc_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic       ack_drive_r;
  logic       ack_pend_r;
  logic       coll_ev;
  logic       tx_drive_r;
  logic       stretch_r;
  logic       ack_slot_r;
  logic       is_ten;
  logic       sp_mode;
  logic       hold_en;
  logic       ev_irq;
  logic       byte_done;
  logic       ack_ok;
  logic       hi_match;
  logic       lo_match;
  logic       a7_match;

  // two-stage synchronisers on both pins
  isc_sync u_sync_sda (.clk(ref_clk), .rst(sys_rst), .din(sda_in),
                       .dout(sda_s));
  isc_sync u_sync_scl (.clk(ref_clk), .rst(sys_rst), .din(scl_in),
                       .dout(scl_s));

  isc_cond u_cond
  (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .sda      (sda_s),
    .scl      (scl_s),
    .start_det(start_det),
    .stop_det (stop_det),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .bus_idle (bus_idle)
  );

  // masked compare used by the seven-bit and 10-bit low byte address checks
  function automatic logic addr_eq(input logic [7:0] a, input logic [7:0] b,
                                   input logic [7:0] m);
    addr_eq = ((a ^ b) & m) == 8'h00;
  endfunction : addr_eq

  // mode decode
  assign is_ten  = port_mode_select[0];
  assign sp_mode = port_mode_select[1];
  assign hold_en = address_hold_enable | data_hold_enable;
  assign byte_done = scl_rise & (bit_cnt_r == 4'h7);
  // seven-bit compare ignores direction bit
  assign a7_match = addr_eq({shift_r[6:0], sda_s}, slave_address_reg,
                            {addr_mask[7:1], 1'b0});
  assign hi_match = ({shift_r[6:2], shift_r[1:0]} ==
                     {isc_pkg::TEN_BIT_HDR,
                      slave_address_reg[isc_pkg::A98_HI_POS],
                      slave_address_reg[isc_pkg::A98_LO_POS]});
  assign lo_match = addr_eq({shift_r[6:0], sda_s}, slave_address_reg,
                            addr_mask);
  // ack level: software picks it on hold, hardware acks otherwise
  assign ack_ok = hold_en ? ~ack_value_select : 1'b1;
  // collision: line found low where we left it high, or still driving sda at a start
  assign coll_ev = (state_r == isc_pkg::ST_TX && scl_rise && !ack_slot_r &&
                    !tx_drive_r && !sda_s) || (start_det && sda_oe);
  // start/stop events raise the flag in sp modes or with enables
  assign ev_irq = (start_det & (sp_mode | start_irq_enable)) |
                  (stop_det & (sp_mode | stop_irq_enable));

  // bit counter and shifter clocked by scl rising edges
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
    end
    else if (start_det || stop_det)
      bit_cnt_r <= 4'h0;
    else if (scl_rise)
    begin
      shift_r   <= {shift_r[6:0], sda_s};
      bit_cnt_r <= (bit_cnt_r == isc_pkg::BIT_ACK_SLOT) ? 4'h0
                   : bit_cnt_r + 4'h1;
    end
  end

  // transfer state machine
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r  <= isc_pkg::ST_IDLE;
      read_dir <= 1'b0;
    end
    else if (start_det)
      state_r <= is_ten ? isc_pkg::ST_ADDR_HI : isc_pkg::ST_ADDR_LO;
    else if (stop_det || coll_ev)
      state_r <= isc_pkg::ST_IDLE;
    else if (byte_done)
    begin
      case (state_r)
        isc_pkg::ST_ADDR_HI:
          if (!hi_match)
            state_r <= isc_pkg::ST_IDLE;
          else if (sda_s && prior_match)
          begin
            state_r  <= isc_pkg::ST_TX;
            read_dir <= 1'b1;
          end
          else if (!sda_s)
            state_r <= isc_pkg::ST_WAIT_UA;
          else
            state_r <= isc_pkg::ST_IDLE;
        isc_pkg::ST_ADDR_LO:
          if (is_ten ? !lo_match : !a7_match)
            state_r <= isc_pkg::ST_IDLE;
          else
          begin
            read_dir <= ~is_ten & sda_s;
            state_r  <= (~is_ten & sda_s) ? isc_pkg::ST_TX
                        : isc_pkg::ST_RX;
          end
        isc_pkg::ST_TX:
          state_r <= isc_pkg::ST_TX;
        default:
          state_r <= state_r;
      endcase
    end
    else if (state_r == isc_pkg::ST_WAIT_UA && addr_write)
      state_r <= isc_pkg::ST_ADDR_LO;
    else if (state_r == isc_pkg::ST_TX && ack_slot_r && scl_rise
             && sda_s)
      state_r <= isc_pkg::ST_IDLE;
  end

  // ack slot marker during the ninth pulse
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_slot_r <= 1'b0;
    else if (start_det || stop_det)
      ack_slot_r <= 1'b0;
    else if (scl_fall)
      ack_slot_r <= (bit_cnt_r == isc_pkg::BIT_ACK_SLOT);
  end

  // ack decision latched at the eighth rise, in the same cycle the buffer loads, from the old flags
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_pend_r <= 1'b0;
    else if (start_det || stop_det)
      ack_pend_r <= 1'b0;
    else if (byte_done)
      ack_pend_r <= ~buffer_full_flag & ~receive_overflow_flag &
                    ((state_r == isc_pkg::ST_RX) |
                     ((state_r == isc_pkg::ST_ADDR_LO) &
                      (is_ten ? lo_match : a7_match)) |
                     ((state_r == isc_pkg::ST_ADDR_HI) & hi_match &
                      (~sda_s | prior_match)));
  end

  // sda drivers: ack while receiving, data while transmitting
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_drive_r <= 1'b0;
      tx_drive_r  <= 1'b0;
    end
    else if (start_det || stop_det || coll_ev)
    begin
      ack_drive_r <= 1'b0;
      tx_drive_r  <= 1'b0;
    end
    else if (scl_fall)
    begin
      ack_drive_r <= (bit_cnt_r == isc_pkg::BIT_ACK_SLOT) && ack_pend_r &&
                     ack_ok;
      // transmitter releases sda in the ack slot
      tx_drive_r  <= (state_r == isc_pkg::ST_TX) &&
                     (bit_cnt_r != isc_pkg::BIT_ACK_SLOT) &&
                     !tx_r[7 - bit_cnt_r[2:0]];
    end
    // first bit goes out as soon as software loads the byte
    else if (tx_load && state_r == isc_pkg::ST_TX && !ack_slot_r &&
             bit_cnt_r == 4'h0)
      tx_drive_r <= ~tx_data[7];
  end

  assign sda_oe  = ack_drive_r | tx_drive_r;
  assign sda_out = 1'b0;

  // transmit holding register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_r <= 8'hff;
    else if (tx_load)
      tx_r <= tx_data;
  end

  // receive buffer, full and overflow flags
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_tx_buffer          <= 8'h00;
      buffer_full_flag      <= 1'b0;
      receive_overflow_flag <= 1'b0;
    end
    else
    begin
      if (byte_done && state_r != isc_pkg::ST_IDLE &&
          state_r != isc_pkg::ST_TX && state_r != isc_pkg::ST_WAIT_UA)
      begin
        if (buffer_full_flag)
          receive_overflow_flag <= 1'b1;
        else if ((state_r != isc_pkg::ST_ADDR_LO || is_ten || a7_match)
                 && (state_r != isc_pkg::ST_ADDR_HI || hi_match))
        begin
          rx_tx_buffer     <= {shift_r[6:0], sda_s};
          buffer_full_flag <= 1'b1;
        end
      end
      else
      begin
        if (buf_read)
          buffer_full_flag <= 1'b0;
        if (ovf_clear)
          receive_overflow_flag <= 1'b0;
      end
    end
  end

  // interrupt flag; hardware set wins over software clear
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      port_interrupt_flag <= 1'b0;
    else if (ev_irq || (ack_slot_r && scl_fall &&
             state_r != isc_pkg::ST_IDLE && sda_s == 1'b0) ||
             (byte_done && hold_en && state_r != isc_pkg::ST_IDLE))
      port_interrupt_flag <= 1'b1;
    else if (irq_clear)
      port_interrupt_flag <= 1'b0;
  end

  // ack-time status and sampled ack level
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_time_status     <= 1'b0;
      ack_received_status <= 1'b0;
    end
    else
    begin
      if (scl_fall && bit_cnt_r == isc_pkg::BIT_ACK_SLOT &&
          state_r != isc_pkg::ST_IDLE && hold_en)
        ack_time_status <= 1'b1;
      else if (scl_fall || start_det || stop_det)
        ack_time_status <= 1'b0;
      if (ack_slot_r && scl_rise)
        ack_received_status <= sda_s;
    end
  end

  // 10-bit address update and prior-match flag
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      address_update_needed <= 1'b0;
      prior_match           <= 1'b0;
    end
    else
    begin
      if (byte_done && is_ten && (state_r == isc_pkg::ST_ADDR_HI &&
          hi_match && !sda_s || state_r == isc_pkg::ST_ADDR_LO))
        address_update_needed <= 1'b1;
      else if (addr_write)
        address_update_needed <= 1'b0;
      if (stop_det || (byte_done && state_r == isc_pkg::ST_ADDR_HI &&
          (!hi_match || !sda_s)))
        prior_match <= 1'b0;
      else if (byte_done && is_ten && state_r == isc_pkg::ST_ADDR_LO &&
               lo_match)
        prior_match <= 1'b1;
    end
  end

  // clock stretch after 10-bit high byte, read address or hold points
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      stretch_r <= 1'b0;
    else if (start_det || stop_det || clock_release)
      stretch_r <= 1'b0;
    else if (scl_fall && ack_slot_r && (address_update_needed ||
             (state_r == isc_pkg::ST_TX && read_dir)))
      stretch_r <= 1'b1;
    else if (scl_fall && hold_en && bit_cnt_r == isc_pkg::BIT_ACK_SLOT
             && state_r != isc_pkg::ST_IDLE)
      stretch_r <= 1'b1;
  end

  assign scl_oe  = stretch_r;
  assign scl_out = 1'b0;

  // collision detection and condition status
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_collision <= 1'b0;
      start_seen    <= 1'b0;
      stop_seen     <= 1'b0;
    end
    else
    begin
      if (coll_ev)
        bus_collision <= 1'b1;
      else if (coll_clear)
        bus_collision <= 1'b0;
      if (start_det)
      begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end
      else if (stop_det)
      begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
      end
    end
  end

  property p_start_flag;
    @(posedge ref_clk) disable iff (sys_rst)
    start_det |=> start_seen;
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start lost");

  property p_ack_nak_full;
    @(posedge ref_clk) disable iff (sys_rst)
    (byte_done && (buffer_full_flag || receive_overflow_flag))
      |=> !ack_pend_r;
  endproperty
  a_ack_nak_full: assert property (p_ack_nak_full) else $error("ack full");

  property p_ua_stretch;
    @(posedge ref_clk) disable iff (sys_rst)
    (address_update_needed && stretch_r && !addr_write && !clock_release
     && !start_det && !stop_det) |=> scl_oe;
  endproperty
  a_ua_stretch: assert property (p_ua_stretch) else $error("ua");

  property p_stop_flag;
    @(posedge ref_clk) disable iff (sys_rst)
    stop_det |=> (stop_seen && !start_seen);
  endproperty
  a_stop_flag: assert property (p_stop_flag) else $error("stop lost");

  property p_nomatch_silent;
    @(posedge ref_clk) disable iff (sys_rst)
    (byte_done && state_r == isc_pkg::ST_ADDR_LO && !is_ten && !a7_match)
      |=> (state_r == isc_pkg::ST_IDLE && !ack_pend_r &&
           $stable(rx_tx_buffer));
  endproperty
  a_nomatch_silent: assert property (p_nomatch_silent)
    else $error("mismatch not silent");

  property p_ack_time_status_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(ack_time_status) |-> $past(hold_en);
  endproperty
  a_ack_time_status_hold: assert property (p_ack_time_status_hold)
    else $error("ack time without hold");

  property p_tx_release;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_r == isc_pkg::ST_TX && ack_slot_r) |-> !tx_drive_r;
  endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("sda held in ack slot");

  cover property (@(posedge ref_clk) disable iff (sys_rst) stop_det);
  cover property (@(posedge ref_clk) disable iff (sys_rst)
                  state_r == isc_pkg::ST_TX);
  cover property (@(posedge ref_clk) disable iff (sys_rst) prior_match);
endmodule : isc_slave

// ===== core/isc_sync.sv
// isc_sync: two-stage synchroniser for one raw pin
// assumes: input is asynchronous to clk; output is a clean level
`timescale 1ns/1ps
module isc_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;

  // two flops, first one read only by the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : isc_sync

// ===== tb/isc_master_model.sv
// isc_master_model: behavioural two-wire bus master for the slave bench
// assumes: open-drain lines resolved in the bench with pull-ups
`timescale 1ns/1ps
module isc_master_model
(
  input  wire logic sda_w,
  input  wire logic scl_w,
  output logic      sda_low,
  output logic      scl_low
);
  // quarter of the 160 ns bit time
  localparam int Q = 40;

  // both lines released at power up, clock stands still
  initial
  begin
    sda_low = 1'b0;
    scl_low = 1'b0;
  end

  // let scl rise and wait while the slave stretches it
  task scl_up;
    scl_low = 1'b0;
    wait (scl_w === 1'b1);
    #1;
  endtask : scl_up

  // sda falls with scl high
  task start_c;
    sda_low = 1'b0;
    scl_up();
    #Q;
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask : start_c

  // sda low then high with no scl low time in between
  task glitch;
    #Q;
    sda_low = 1'b1;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask : glitch

  // repeated start from the low clock phase
  task restart;
    sda_low = 1'b0;
    #Q;
    scl_up();
    #Q;
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask : restart

  // sda rises with scl high, lines left released
  task stop_c;
    sda_low = 1'b1;
    #Q;
    scl_up();
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask : stop_c

  // one clock pulse: drive b, sample the line while scl high
  task bit_x(input logic b, output logic r);
    sda_low = ~b;
    #Q;
    scl_up();
    #Q;
    r = sda_w;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask : bit_x

  // byte msb first, line released in the ninth pulse
  task write_byte(input logic [7:0] dv, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(dv[i], r);
    bit_x(1'b1, ack);
  endtask : write_byte

  // byte from the slave; collide pulls sda low in all eight data pulses
  task read_byte(input logic nack, input logic collide,
                 output logic [7:0] dv);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(~collide, dv[i]);
    bit_x(nack, r);
  endtask : read_byte
endmodule : isc_master_model

// ===== tb/isc_slave_tb.sv
// isc_slave_tb: self-checking bench for the two-wire slave front end
// assumes: master model in tb/, pull-ups on both lines
`timescale 1ns/1ps
module isc_slave_tb;
  logic       ref_clk, sys_rst, sda_w, scl_w, sda_low, scl_low;
  logic       sda_out, sda_oe, scl_out, scl_oe, addr_write, clock_release;
  logic [1:0] port_mode_select;
  logic [7:0] slave_address_reg, addr_mask, tx_data, tx_val, rx_tx_buffer;
  logic       start_irq_enable, stop_irq_enable, ack_value_select, tx_load;
  logic       address_hold_enable, data_hold_enable, buf_read, irq_clear;
  logic       ovf_clear, coll_clear, buffer_full_flag, receive_overflow_flag;
  logic       ack_received_status, ack_time_status, port_interrupt_flag;
  logic       address_update_needed, prior_match, read_dir, start_seen;
  logic       stop_seen, bus_collision, bus_idle, ack, clr_seen;
  logic       ackt_seen, ua_seen;
  logic [7:0] d, str_cnt;
  int         error_cnt, num_checks, cyc;
  localparam logic [7:0] LO_ADDR = 8'h5a;

  // open-drain resolution with pull-ups
  assign sda_w = ~(sda_low | sda_oe);
  assign scl_w = ~(scl_low | scl_oe);

  isc_slave isc_slave_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .port_mode_select(port_mode_select),
    .slave_address_reg(slave_address_reg), .addr_write(addr_write),
    .addr_mask(addr_mask), .start_irq_enable(start_irq_enable),
    .stop_irq_enable(stop_irq_enable),
    .address_hold_enable(address_hold_enable),
    .data_hold_enable(data_hold_enable), .ack_value_select(ack_value_select),
    .clock_release(clock_release), .tx_data(tx_data), .tx_load(tx_load),
    .buf_read(buf_read), .irq_clear(irq_clear), .ovf_clear(ovf_clear),
    .coll_clear(coll_clear), .rx_tx_buffer(rx_tx_buffer),
    .buffer_full_flag(buffer_full_flag),
    .receive_overflow_flag(receive_overflow_flag),
    .ack_received_status(ack_received_status),
    .ack_time_status(ack_time_status),
    .port_interrupt_flag(port_interrupt_flag),
    .address_update_needed(address_update_needed),
    .prior_match(prior_match), .read_dir(read_dir), .start_seen(start_seen),
    .stop_seen(stop_seen), .bus_collision(bus_collision),
    .bus_idle(bus_idle));

  isc_master_model isc_master_model_i (.sda_w(sda_w), .scl_w(scl_w),
    .sda_low(sda_low), .scl_low(scl_low));

  // 125 MHz core clock
  always #4 ref_clk = ~ref_clk;

  // software side: reload and release stretches, rewrite the address
  always @(posedge ref_clk)
  begin
    tx_load       <= 1'b0;
    clock_release <= 1'b0;
    addr_write    <= 1'b0;
    str_cnt       <= scl_oe ? str_cnt + 8'h01 : 8'h00;
    if (str_cnt == 8'h0a && read_dir === 1'b1)
    begin
      tx_data <= tx_val;
      tx_load <= 1'b1;
    end
    if (str_cnt == 8'h0c)
      clock_release <= 1'b1;
    if (str_cnt == 8'h08 && address_update_needed === 1'b1)
    begin
      slave_address_reg <= (slave_address_reg == 8'h02) ? LO_ADDR : 8'h02;
      addr_write        <= 1'b1;
    end
    if (ack_time_status === 1'b1)
      ackt_seen <= 1'b1;
    if (address_update_needed === 1'b1)
      ua_seen <= 1'b1;
    if (clr_seen)
    begin
      ackt_seen <= 1'b0;
      ua_seen   <= 1'b0;
    end
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // compare one value against its expectation
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // mode, address and hold/nack setup on a clock edge
  task cfg(input logic [1:0] m, input logic [7:0] a, input logic [2:0] h);
    @(posedge ref_clk);
    port_mode_select    <= m;
    slave_address_reg   <= a;
    start_irq_enable    <= h[2];
    stop_irq_enable     <= h[2];
    address_hold_enable <= h[1];
    data_hold_enable    <= h[1];
    ack_value_select    <= h[0];
    clr_seen            <= 1'b1;
    @(posedge ref_clk);
    clr_seen            <= 1'b0;
    #1;
  endtask : cfg

  // software clears the buffer full, interrupt, overflow and collision flags
  task sw_clear;
    @(posedge ref_clk);
    {buf_read, irq_clear, ovf_clear, coll_clear} <= 4'hf;
    @(posedge ref_clk);
    {buf_read, irq_clear, ovf_clear, coll_clear} <= 4'h0;
    #1;
  endtask : sw_clear

  // counts, verdict and end of run
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    {ref_clk, addr_write, clock_release, tx_load, clr_seen} = 5'h00;
    {buf_read, irq_clear, ovf_clear, coll_clear} = 4'h0;
    {ackt_seen, ua_seen, str_cnt, cyc} = '0;
    {start_irq_enable, stop_irq_enable, ack_value_select} = 3'h0;
    {address_hold_enable, data_hold_enable} = 2'h0;
    {tx_data, tx_val, slave_address_reg} = {8'h00, 8'h3c, 8'ha4};
    {port_mode_select, addr_mask, sys_rst} = {isc_pkg::MODE_7BIT, 8'hff, 1'b1};
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check(rx_tx_buffer, 8'h00);
    check({buffer_full_flag, receive_overflow_flag, ack_received_status,
           ack_time_status, port_interrupt_flag, address_update_needed,
           prior_match, read_dir}, 8'h00);
    check({4'h0, sda_out, scl_out, sda_oe, scl_oe}, 8'h00);
    isc_master_model_i.glitch();
    check({6'h00, start_seen, stop_seen}, 8'h02);
    // 7-bit write, automatic ack, full buffer refuses
    isc_master_model_i.start_c();
    check({7'h00, port_interrupt_flag}, 8'h00);
    isc_master_model_i.write_byte(8'ha4, ack);
    check({7'h00, ack}, 8'h00);
    check(rx_tx_buffer, 8'ha4);
    check({5'h00, buffer_full_flag, port_interrupt_flag, read_dir},
          8'h06);
    isc_master_model_i.write_byte(8'h11, ack);
    check({7'h00, ack}, 8'h01);
    check({7'h00, receive_overflow_flag}, 8'h01);
    sw_clear();
    isc_master_model_i.write_byte(8'h22, ack);
    check({ack, 7'h00} | {1'b0, rx_tx_buffer[6:0]}, 8'h22);
    isc_master_model_i.stop_c();
    check({6'h00, stop_seen, bus_idle}, 8'h03);
    // address mismatch stays silent
    sw_clear();
    isc_master_model_i.start_c();
    check({7'h00, bus_idle}, 8'h00);
    isc_master_model_i.write_byte(8'h30, ack);
    check({5'h00, ack, buffer_full_flag, port_interrupt_flag}, 8'h04);
    isc_master_model_i.stop_c();
    // read request, direction bit outside the compare
    isc_master_model_i.start_c();
    isc_master_model_i.write_byte(8'ha5, ack);
    check({6'h00, ack, read_dir}, 8'h01);
    isc_master_model_i.read_byte(1'b0, 1'b0, d);
    tx_val = 8'hc3;
    check(d, 8'h3c);
    check({7'h00, ack_received_status}, 8'h00);
    isc_master_model_i.read_byte(1'b1, 1'b0, d);
    check(d, 8'hc3);
    check({7'h00, ack_received_status}, 8'h01);
    isc_master_model_i.stop_c();
    sw_clear();
    // master holds sda low while the slave sends ones
    isc_master_model_i.start_c();
    isc_master_model_i.write_byte(8'ha5, ack);
    isc_master_model_i.read_byte(1'b1, 1'b1, d);
    check({7'h00, bus_collision}, 8'h01);
    isc_master_model_i.stop_c();
    sw_clear();
    // hold enables: software chooses nack
    cfg(isc_pkg::MODE_7BIT, 8'ha4, 3'b011);
    isc_master_model_i.start_c();
    isc_master_model_i.write_byte(8'ha4, ack);
    check({6'h00, ack, ackt_seen}, 8'h03);
    isc_master_model_i.stop_c();
    // start/stop interrupt by enable bit, then by mode
    for (int k = 0; k < 2; k++)
    begin
      cfg(k ? isc_pkg::MODE_7BIT_SP : isc_pkg::MODE_7BIT, 8'ha4,
          k ? 3'b000 : 3'b100);
      sw_clear();
      isc_master_model_i.start_c();
      check({7'h00, port_interrupt_flag}, 8'h01);
      sw_clear();
      isc_master_model_i.stop_c();
      check({7'h00, port_interrupt_flag}, 8'h01);
    end
    // 10-bit: high and low match, restart, read
    cfg(isc_pkg::MODE_10BIT, 8'h02, 3'b000);
    sw_clear();
    isc_master_model_i.start_c();
    isc_master_model_i.write_byte(8'hf2, ack);
    check({7'h00, ack}, 8'h00);
    sw_clear();
    isc_master_model_i.write_byte(LO_ADDR, ack);
    check({5'h00, ack, ua_seen, prior_match}, 8'h03);
    sw_clear();
    isc_master_model_i.restart();
    isc_master_model_i.write_byte(8'hf3, ack);
    check({6'h00, ack, read_dir}, 8'h01);
    isc_master_model_i.read_byte(1'b1, 1'b0, d);
    check(d, 8'hc3);
    isc_master_model_i.stop_c();
    check({7'h00, prior_match}, 8'h00);
    end_of_test();
  end
endmodule : isc_slave_tb
